//--- logic/umfc_uart.sv
`default_nettype none
// Behaviour
// - bit rate is source over (divisor+1) over sixteen
// - mode code zero disables and resets machines
// - codes 100,101,110 select 7,8,9 bits
// - data sits from bit 0 upward
// - bit order select chooses LSB or MSB first
// - bit order honoured only for 8-bit characters
// - data logic switch inverts transmit data
// - data logic switch inverts received data
// - polarity inversion flips both pins, all bits
// - idle output high or floating when open-drain
// - clear-to-send low required to start
// - cts rising finishes current character, then halts
// - rts driven low when ready to receive
// - flow control disabled makes pin plain I/O
// - select 0 is cts, 1 is rts
module umfc_uart (
   input  wire logic       ref_clk,              // system clock, 50 MHz
   input  wire logic       srst,                 // sync reset, high
   input  wire logic [2:0] serial_mode_select,   // mode code
   input  wire logic       transmit_enable_bit,  // transmit enable
   input  wire logic       receive_enable_bit,   // receive enable
   input  wire logic [7:0] baud_divisor_reg,     // baud divisor
   input  wire logic       count_source_div8,    // 0 = /1, 1 = /8 source
   input  wire logic       bit_order_select,     // 1 = MSB first
   input  wire logic       data_invert,          // data logic switching
   input  wire logic       pin_invert,           // pin polarity inversion
   input  wire logic       open_drain,           // open-drain output
   input  wire logic       flow_control_disable, // 1 = pin is plain I/O
   input  wire logic       flow_control_select,  // 0 = cts, 1 = rts
   input  wire logic       gpio_out,             // port value when plain I/O
   input  wire logic       gpio_oe,              // port drive when plain I/O
   input  wire logic [8:0] transmit_buffer,      // data to send
   input  wire logic       transmit_write,       // pulse: buffer written
   input  wire logic       receive_read,         // pulse: buffer read
   input  wire logic       serial_in_pin,        // serial input
   input  wire logic       flow_control_pin_in,  // shared pin level
   output logic            serial_out_pin,       // serial output level
   output logic            serial_out_oe,        // serial output enable
   output logic            flow_control_pin_out, // shared pin drive level
   output logic            flow_control_pin_oe,  // shared pin drive enable
   output logic [8:0]      receive_buffer,       // received character
   output logic            receive_full,         // receive buffer holds data
   output logic            transmit_empty,       // transmit buffer free
   output logic            transmitter_idle,     // shift register empty
   output logic            overrun_error,        // character lost
   output logic            framing_error         // stop bit low
);
   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   typedef enum {UMFC_IDLE, UMFC_START, UMFC_DATA, UMFC_STOP} umfc_state_t;

   logic       mode_on;    // a uart mode is selected
   logic [3:0] char_len;   // data bits per character
   logic       msb_first;  // effective bit order
   logic       cts_mode;   // clear-to-send active
   logic       rts_mode;   // request-to-send active
   logic       tick;       // sixteenth-bit tick
   logic       rx_line;    // input after polarity handling

   always_comb begin
      mode_on  = 1'b1;
      char_len = 4'h8;
      case (serial_mode_select)
         umfc_pkg::MODE_UART7: char_len = 4'h7;
         umfc_pkg::MODE_UART8: char_len = 4'h8;
         umfc_pkg::MODE_UART9: char_len = 4'h9;
         default:              mode_on  = 1'b0;
      endcase
   end
   // other lengths keep lsb first
   assign msb_first = bit_order_select && (char_len == 4'h8);
   assign cts_mode  = !flow_control_disable && !flow_control_select;
   assign rts_mode  = !flow_control_disable && flow_control_select;
   assign rx_line   = serial_in_pin ^ pin_invert;

   // shared divider: slow source and reload counter
   umfc_baud #(
      .DIV_W (8)
   ) u_baud (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .run      (mode_on),
      .src_div8 (count_source_div8),
      .divisor  (baud_divisor_reg),
      .tick     (tick)
   );

   // ---------------------------------------------------------------
   // transmitter
   // ---------------------------------------------------------------
   umfc_state_t tx_st, next_tx_st;
   logic [8:0]  tx_hold, next_tx_hold;     // transmit buffer copy
   logic        tx_full, next_tx_full;     // buffer holds a character
   logic [8:0]  tx_sh, next_tx_sh;         // shift register
   logic [3:0]  tx_tk, next_tx_tk;         // tick within bit
   logic [3:0]  tx_bit, next_tx_bit;       // data bits sent
   logic        tx_line, next_tx_line;     // logical line level

   // next transmitter state
   always_comb begin
      next_tx_st   = tx_st;
      next_tx_hold = tx_hold;
      next_tx_full = tx_full;
      next_tx_sh   = tx_sh;
      next_tx_tk   = tx_tk;
      next_tx_bit  = tx_bit;
      next_tx_line = tx_line;
      if (transmit_write) begin
         next_tx_hold = data_invert ? ~transmit_buffer : transmit_buffer;
         next_tx_full = 1'b1;
      end
      if (!mode_on) begin
         // disabled interface: machine and line return to idle
         next_tx_st   = UMFC_IDLE;
         next_tx_full = 1'b0;
         next_tx_line = 1'b1;
      end else if (tick) begin
         next_tx_tk = tx_tk + 4'h1;
         case (tx_st)
            UMFC_IDLE: begin
               next_tx_tk   = 4'h0;
               next_tx_line = 1'b1;
               // cts is looked at only here, so a rise mid-character
               // lets the character finish before holding off
               if (tx_full && transmit_enable_bit &&
                   !(cts_mode && flow_control_pin_in)) begin
                  next_tx_st   = UMFC_START;
                  next_tx_sh   = tx_hold;
                  next_tx_full = transmit_write;
                  next_tx_line = 1'b0;
               end
            end
            UMFC_START: begin
               if (tx_tk == umfc_pkg::TICK_LAST) begin
                  next_tx_st   = UMFC_DATA;
                  next_tx_bit  = 4'h0;
                  next_tx_line = msb_first ? tx_sh[7] : tx_sh[0];
               end
            end
            UMFC_DATA: begin
               if (tx_tk == umfc_pkg::TICK_LAST) begin
                  next_tx_bit = tx_bit + 4'h1;
                  next_tx_sh  = msb_first ? {tx_sh[8], tx_sh[6:0], 1'b0}
                                          : {1'b0, tx_sh[8:1]};
                  if (tx_bit + 4'h1 == char_len) begin
                     next_tx_st   = UMFC_STOP;
                     next_tx_line = 1'b1;
                  end else begin
                     next_tx_line = msb_first ? tx_sh[6] : tx_sh[1];
                  end
               end
            end
            UMFC_STOP: begin
               if (tx_tk == umfc_pkg::TICK_LAST) begin
                  next_tx_st = UMFC_IDLE;
               end
            end
            default: next_tx_st = UMFC_IDLE;
         endcase
      end
   end

   // register transmitter
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tx_st   <= UMFC_IDLE;
         tx_hold <= umfc_pkg::BUF_RESET;
         tx_full <= 1'b0;
         tx_sh   <= umfc_pkg::BUF_RESET;
         tx_tk   <= 4'h0;
         tx_bit  <= 4'h0;
         tx_line <= 1'b1;
      end else begin
         tx_st   <= next_tx_st;
         tx_hold <= next_tx_hold;
         tx_full <= next_tx_full;
         tx_sh   <= next_tx_sh;
         tx_tk   <= next_tx_tk;
         tx_bit  <= next_tx_bit;
         tx_line <= next_tx_line;
      end
   end

   // ---------------------------------------------------------------
   // receiver
   // ---------------------------------------------------------------
   umfc_state_t rx_st, next_rx_st;
   logic [8:0]  rx_sh, next_rx_sh;         // incoming bits
   logic [3:0]  rx_tk, next_rx_tk;         // tick within bit
   logic [3:0]  rx_bit, next_rx_bit;       // data bits taken
   logic [8:0]  next_rbuf;
   logic        next_rfull, next_oer, next_fer;
   logic [8:0]  rx_word;                   // right-aligned character

   // align a finished character to bit 0 for the buffer
   always_comb begin
      rx_word = rx_sh >> (4'h9 - char_len);
      if (msb_first) begin
         rx_word = rx_sh;
      end
   end

   // next receiver state
   always_comb begin
      next_rx_st  = rx_st;
      next_rx_sh  = rx_sh;
      next_rx_tk  = rx_tk;
      next_rx_bit = rx_bit;
      next_rbuf   = receive_buffer;
      next_rfull  = receive_full && !receive_read;
      next_oer    = overrun_error && !receive_read;
      next_fer    = framing_error && !receive_read;
      if (!mode_on || !receive_enable_bit) begin
         next_rx_st = UMFC_IDLE;
         if (!mode_on) begin
            next_rfull = 1'b0;
         end
      end else if (tick) begin
         next_rx_tk = rx_tk + 4'h1;
         case (rx_st)
            UMFC_IDLE: begin
               next_rx_tk = 4'h0;
               if (!rx_line) begin
                  next_rx_st = UMFC_START;
                  next_rx_tk = 4'h1;
               end
            end
            UMFC_START: begin
               // a glitch that is gone by mid-bit is not a start
               if (rx_tk == umfc_pkg::TICK_MID && rx_line) begin
                  next_rx_st = UMFC_IDLE;
               end else if (rx_tk == umfc_pkg::TICK_LAST) begin
                  next_rx_st  = UMFC_DATA;
                  next_rx_bit = 4'h0;
               end
            end
            UMFC_DATA: begin
               if (rx_tk == umfc_pkg::TICK_MID) begin
                  next_rx_sh = msb_first ? {1'b0, rx_sh[6:0], rx_line}
                                         : {rx_line, rx_sh[8:1]};
               end
               if (rx_tk == umfc_pkg::TICK_LAST) begin
                  next_rx_bit = rx_bit + 4'h1;
                  if (rx_bit + 4'h1 == char_len) begin
                     next_rx_st = UMFC_STOP;
                  end
               end
            end
            UMFC_STOP: begin
               if (rx_tk == umfc_pkg::TICK_MID) begin
                  next_rx_st = UMFC_IDLE;
                  // set wins over a same-cycle read
                  next_rbuf  = data_invert ? ~rx_word : rx_word;
                  next_rfull = 1'b1;
                  next_oer   = next_oer || (receive_full && !receive_read);
                  next_fer   = !rx_line;
               end
            end
            default: next_rx_st = UMFC_IDLE;
         endcase
      end
   end

   // register receiver and the pin drivers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_st                <= UMFC_IDLE;
         rx_sh                <= umfc_pkg::BUF_RESET;
         rx_tk                <= 4'h0;
         rx_bit               <= 4'h0;
         receive_buffer       <= umfc_pkg::BUF_RESET;
         receive_full         <= 1'b0;
         overrun_error        <= 1'b0;
         framing_error        <= 1'b0;
         serial_out_pin       <= 1'b1;
         serial_out_oe        <= 1'b0;
         flow_control_pin_out <= 1'b1;
         flow_control_pin_oe  <= 1'b0;
         transmit_empty       <= 1'b1;
         transmitter_idle     <= 1'b1;
      end else begin
         rx_st                <= next_rx_st;
         rx_sh                <= next_rx_sh;
         rx_tk                <= next_rx_tk;
         rx_bit               <= next_rx_bit;
         receive_buffer       <= next_rbuf;
         receive_full         <= next_rfull;
         overrun_error        <= next_oer;
         framing_error        <= next_fer;
         serial_out_pin       <= next_tx_line ^ pin_invert;
         // open-drain only pulls low, so a high level floats
         serial_out_oe        <= mode_on &&
                                 !(open_drain && (next_tx_line ^ pin_invert));
         if (rts_mode) begin
            flow_control_pin_out <= !(mode_on && receive_enable_bit && !next_rfull);
            flow_control_pin_oe  <= 1'b1;
         end else if (cts_mode) begin
            flow_control_pin_out <= 1'b1;
            flow_control_pin_oe  <= 1'b0;
         end else begin
            flow_control_pin_out <= gpio_out;
            flow_control_pin_oe  <= gpio_oe;
         end
         transmit_empty       <= !next_tx_full;
         transmitter_idle     <= (next_tx_st == UMFC_IDLE);
      end
   end
endmodule
`default_nettype wire

//--- logic/umfc_pkg.sv
`default_nettype none
package umfc_pkg;
   // ---------------------------------------------------------------
   // serial mode select codes
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_OFF   = 3'h0;   // interface disabled
   localparam logic [2:0] MODE_UART7 = 3'h4;   // 7-bit characters
   localparam logic [2:0] MODE_UART8 = 3'h5;   // 8-bit characters
   localparam logic [2:0] MODE_UART9 = 3'h6;   // 9-bit characters
   // ---------------------------------------------------------------
   // timing and layout
   // ---------------------------------------------------------------
   localparam int          OVERSAMPLE  = 16;       // ticks per bit
   localparam logic [3:0]  TICK_LAST   = 4'hF;     // last tick of a bit
   localparam logic [3:0]  TICK_MID    = 4'h7;     // mid-bit sample tick
   localparam int          PRESCALE8   = 8;        // slow count source ratio
   localparam logic [2:0]  PRESCALE_LAST = 3'h7;   // last cycle of the /8 divider
   localparam int          DATA_W      = 9;        // buffer width
   localparam logic [8:0]  BUF_RESET   = 9'h000;   // buffer reset value
   localparam logic [7:0]  DIV_RESET   = 8'h00;    // divisor counter reset value
endpackage
`default_nettype wire

//--- logic/umfc_baud.sv
`default_nettype none
// ---------------------------------------------------------------
// baud tick generator: prescale, then reloadable down-counter
// ---------------------------------------------------------------
module umfc_baud #(
   parameter int DIV_W = 8
) (
   input  wire logic             ref_clk,      // system clock
   input  wire logic             srst,         // sync reset, high
   input  wire logic             run,          // low holds the counter
   input  wire logic             src_div8,     // 1 selects the /8 source
   input  wire logic [DIV_W-1:0] divisor,      // divides by divisor+1
   output logic                  tick          // one sixteenth-bit pulse
);
   logic [2:0]       pre;                      // /8 prescaler
   logic [2:0]       next_pre;
   logic [DIV_W-1:0] cnt;                      // divisor down-counter
   logic [DIV_W-1:0] next_cnt;
   logic             next_tick;
   logic             src_en;                   // count source enable

   // next values of prescaler and divisor counter
   always_comb begin
      next_pre  = pre + 3'h1;
      src_en    = src_div8 ? (pre == umfc_pkg::PRESCALE_LAST) : 1'b1;
      next_cnt  = cnt;
      next_tick = 1'b0;
      if (!run) begin
         next_pre = 3'h0;
         next_cnt = divisor;
      end else if (src_en) begin
         if (cnt == '0) begin
            // reload on underflow, so each period is divisor+1 sources
            next_cnt  = divisor;
            next_tick = 1'b1;
         end else begin
            next_cnt = cnt - {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // register stage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pre  <= 3'h0;
         cnt  <= umfc_pkg::DIV_RESET;
         tick <= 1'b0;
      end else begin
         pre  <= next_pre;
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule
`default_nettype wire

//--- tb/umfc_sva.sv
`default_nettype none
// ---------------------------------------------------------------
// port checks for the serial channel
// ---------------------------------------------------------------
module umfc_sva (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic [2:0] serial_mode_select,
   input wire logic       receive_enable_bit,
   input wire logic       pin_invert,
   input wire logic       open_drain,
   input wire logic       flow_control_disable,
   input wire logic       flow_control_select,
   input wire logic       gpio_out,
   input wire logic       gpio_oe,
   input wire logic       flow_control_pin_in,
   input wire logic       serial_out_pin,
   input wire logic       serial_out_oe,
   input wire logic       flow_control_pin_out,
   input wire logic       flow_control_pin_oe,
   input wire logic       receive_full,
   input wire logic       transmit_empty,
   input wire logic       transmitter_idle
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   logic on;   // a uart code is selected
   logic idl;  // uart selected, shift register empty
   logic rts;  // shared pin acts as ready-to-receive
   logic cts;  // shared pin acts as clear-to-send
   assign on  = serial_mode_select inside {umfc_pkg::MODE_UART7, umfc_pkg::MODE_UART8,
                                           umfc_pkg::MODE_UART9};
   assign idl = on && transmitter_idle;
   assign rts = on && !flow_control_disable && flow_control_select;
   assign cts = !flow_control_disable && !flow_control_select;
   // idle checks span three cycles so a start launched mid-window never counts
   a_off_clear: assert property (!on [*2] |-> !serial_out_oe && !receive_full
                                 && transmit_empty && transmitter_idle)
      else $error("channel not cleared while off");
   a_idle_high: assert property ((idl && !pin_invert && !open_drain) [*3]
                                 |-> $past(serial_out_pin) && $past(serial_out_oe))
      else $error("idle line not driven high");
   a_inv_idle: assert property ((idl && pin_invert && !open_drain) [*3]
                                |-> !$past(serial_out_pin))
      else $error("inverted idle line not low");
   a_od_float: assert property ((idl && open_drain && !pin_invert) [*3]
                                |-> !$past(serial_out_oe))
      else $error("open-drain idle line driven");
   // clear-to-send held high four cycles before judging
   a_cts_block: assert property ((idl && cts && flow_control_pin_in) [*4]
                                 |=> transmitter_idle)
      else $error("start while clear-to-send high");
   a_cts_input: assert property (cts [*2] |-> !flow_control_pin_oe)
      else $error("clear-to-send pin driven");
   a_rts_busy: assert property ((rts && receive_full) [*2]
                                |-> flow_control_pin_oe && flow_control_pin_out)
      else $error("ready shown while buffer full");
   a_rts_ready: assert property ((rts && receive_enable_bit && !receive_full) [*2]
                                 |-> flow_control_pin_oe && !flow_control_pin_out)
      else $error("ready not shown");
   a_gpio_pass: assert property (flow_control_disable [*2]
                                 |-> flow_control_pin_out == $past(gpio_out)
                                 && flow_control_pin_oe == $past(gpio_oe))
      else $error("plain pin does not follow port");
endmodule
bind umfc_uart umfc_sva u_sva (.*);
`default_nettype wire

//--- tb/umfc_remote.sv
`default_nettype none
// ---------------------------------------------------------------
// remote serial device: frames both ways, owns clear-to-send
// ---------------------------------------------------------------
module umfc_remote (
   input  wire logic ref_clk,  // shared clock
   input  wire logic line_in,  // device output line, pulled up
   input  wire logic inv,      // line polarity agreed with the device
   output logic      line_out, // into the device input
   output var logic  cts_n     // low lets the device send
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b1;  // true level, idle high between frames
   initial cts_n = 1'b0;
   assign line_out = drv ^ inv;
   // start, nb data bits from bit 0, one stop
   task automatic send(input int bc, nb, input logic [8:0] d);
      drv <= 1'b0;
      repeat (bc) @(posedge ref_clk);
      for (int i = 0; i < nb; i++) begin
         drv <= d[i];
         repeat (bc) @(posedge ref_clk);
      end
      drv <= 1'b1;
      repeat (bc) @(posedge ref_clk);
   endtask
   // bits kept in line order, sampled mid-bit; ends at mid-stop
   task automatic recv(input int bc, nb, output logic [8:0] d, output logic stp);
      int w = 0;
      d = 9'h000;
      while ((line_in ^ inv) && w < 5000) begin
         @(posedge ref_clk);
         w++;
      end
      repeat (bc / 2) @(posedge ref_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (bc) @(posedge ref_clk);
         d[i] = line_in ^ inv;
      end
      repeat (bc) @(posedge ref_clk);
      stp = line_in ^ inv;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
// ---------------------------------------------------------------
// bench for the serial channel
// ---------------------------------------------------------------
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk, srst = 1'b1, line, stp, cts_n, serial_in_pin, flow_control_pin_in;
   logic [2:0] serial_mode_select = 3'h0;
   logic [7:0] baud_divisor_reg = 8'h01;  // divide by two: 32 clocks a bit
   logic [8:0] transmit_buffer = 9'h000, receive_buffer, got;
   logic       transmit_enable_bit = 1'b0, receive_enable_bit = 1'b0, count_source_div8 = 1'b0;
   logic       bit_order_select = 1'b0, data_invert = 1'b0, pin_invert = 1'b0, open_drain = 1'b0;
   logic       flow_control_disable = 1'b0, flow_control_select = 1'b0, gpio_out = 1'b0;
   logic       gpio_oe = 1'b0, transmit_write = 1'b0, receive_read = 1'b0, serial_out_pin;
   logic       serial_out_oe, flow_control_pin_out, flow_control_pin_oe, receive_full;
   logic       transmit_empty, transmitter_idle, overrun_error, framing_error;
   int         bad_count = 0, cmp_count = 0, bc = 32;
   // pull-up on the data line; shared pin resolved from both ends
   assign line                = serial_out_oe ? serial_out_pin : 1'b1;
   assign flow_control_pin_in = flow_control_pin_oe ? flow_control_pin_out : cts_n;
   umfc_uart   dut (.*);
   umfc_remote u_rem (.ref_clk, .line_in(line), .line_out(serial_in_pin),
                      .inv(pin_invert), .cts_n);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic check(input logic [8:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic put(input logic [8:0] d);
      transmit_buffer <= d;
      transmit_write  <= 1'b1;
      @(posedge ref_clk);
      transmit_write  <= 1'b0;
   endtask
   task automatic rd;
      receive_read <= 1'b1;
      @(posedge ref_clk);
      receive_read <= 1'b0;
   endtask
   // one character either way; upper buffer bits are undefined, so masked
   task automatic xf(input logic r, input logic [2:0] m, input logic o, di, pi,
                     input logic [8:0] d, x, input int nb);
      serial_mode_select <= m;
      bit_order_select   <= o;
      data_invert        <= di;
      pin_invert         <= pi;
      cyc(4);
      check(9'(line), 9'(!pi));
      if (r) begin
         u_rem.send(bc, nb, d);
         cyc(2);
         check(9'({receive_full, overrun_error, framing_error}), 9'h004);
         check(receive_buffer & 9'((1 << nb) - 1), x);
         rd();
         cyc(2);
         check(9'(receive_full), 9'h000);
      end else begin
         put(d);
         u_rem.recv(bc, nb, got, stp);
         check(got, x);
         check(9'(stp), 9'h001);
         cyc(bc);
      end
   endtask
   // start bit alone is low, so its length is one bit time
   task automatic t_rate(input logic [7:0] n, input logic s8, input int x);
      int k = 0;
      baud_divisor_reg  <= n;
      count_source_div8 <= s8;
      put(9'h0FF);
      while (line && k < 4000) begin
         @(posedge ref_clk);
         k++;
      end
      k = 0;
      while (!line && k < 4000) begin
         @(posedge ref_clk);
         k++;
      end
      check(9'(k), 9'(x));
      cyc(10 * x);
      baud_divisor_reg  <= 8'h01;
      count_source_div8 <= 1'b0;
      cyc(2);
   endtask
   task automatic t_cts;
      u_rem.cts_n <= 1'b1;
      put(9'h0F0);
      cyc(3 * bc);
      check(9'({transmitter_idle, line}), 9'h003);
      u_rem.cts_n <= 1'b0;
      u_rem.recv(bc, 8, got, stp);
      check(got, 9'h0F0);
      cyc(bc);
      put(9'h033);
      fork
         u_rem.recv(bc, 8, got, stp);
         begin
            cyc(bc);
            put(9'h0CC);
            u_rem.cts_n <= 1'b1;
         end
      join
      check(got, 9'h033);
      cyc(4 * bc);
      check(9'({transmitter_idle, line}), 9'h003);
      u_rem.cts_n <= 1'b0;
      u_rem.recv(bc, 8, got, stp);
      check(got, 9'h0CC);
      cyc(bc);
   endtask
   task automatic t_rts;
      flow_control_select <= 1'b1;
      cyc(3);
      check(9'({flow_control_pin_oe, flow_control_pin_out}), 9'h002);
      u_rem.send(bc, 8, 9'h05A);
      cyc(3);
      check(9'(flow_control_pin_out), 9'h001);
      u_rem.send(bc, 8, 9'h0A5);
      check(9'({overrun_error, flow_control_pin_out}), 9'h003);
      rd();
      cyc(3);
      check(9'(flow_control_pin_out), 9'h000);
      receive_enable_bit <= 1'b0;
      cyc(3);
      check(9'(flow_control_pin_out), 9'h001);
      flow_control_disable <= 1'b1;
      gpio_oe              <= 1'b1;
      receive_enable_bit   <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         gpio_out <= v[0];
         cyc(3);
         check(9'({flow_control_pin_oe, flow_control_pin_out}), 9'(2 + v));
      end
      flow_control_disable <= 1'b0;
      flow_control_select  <= 1'b0;
      gpio_oe              <= 1'b0;
      cyc(3);
      check(9'(flow_control_pin_oe), 9'h000);
   endtask
   // abort mid-frame, then the recovery order, then open-drain traffic
   task automatic t_abort;
      put(9'h0AA);
      cyc(3 * bc);
      transmit_enable_bit <= 1'b0;
      receive_enable_bit  <= 1'b0;
      cyc(1);
      serial_mode_select <= umfc_pkg::MODE_OFF;
      cyc(3);
      check(9'({serial_out_oe, transmitter_idle, transmit_empty, line}), 9'h007);
      serial_mode_select <= umfc_pkg::MODE_UART8;
      open_drain         <= 1'b1;
      cyc(2);
      transmit_enable_bit <= 1'b1;
      receive_enable_bit  <= 1'b1;
      cyc(4);
      check(9'(serial_out_oe), 9'h000);
      put(9'h069);
      u_rem.recv(bc, 8, got, stp);
      check(got, 9'h069);
      cyc(bc);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      cyc(2);
      check(9'({serial_out_oe, transmit_empty, transmitter_idle, receive_full}), 9'h006);
      transmit_enable_bit <= 1'b1;
      receive_enable_bit  <= 1'b1;
      xf(0, umfc_pkg::MODE_UART7, 1, 0, 0, 9'h0B5, 9'h035, 7);
      xf(0, umfc_pkg::MODE_UART8, 0, 0, 0, 9'h01D, 9'h01D, 8);
      xf(0, umfc_pkg::MODE_UART8, 1, 0, 0, 9'h01D, 9'h0B8, 8);
      xf(0, umfc_pkg::MODE_UART9, 1, 0, 0, 9'h1C5, 9'h1C5, 9);
      xf(0, umfc_pkg::MODE_UART8, 0, 1, 0, 9'h01D, 9'h0E2, 8);
      xf(0, umfc_pkg::MODE_UART8, 0, 0, 1, 9'h01D, 9'h01D, 8);
      xf(1, umfc_pkg::MODE_UART8, 0, 0, 1, 9'h01D, 9'h01D, 8);
      xf(1, umfc_pkg::MODE_UART7, 1, 0, 0, 9'h031, 9'h031, 7);
      xf(1, umfc_pkg::MODE_UART8, 1, 0, 0, 9'h01D, 9'h0B8, 8);
      xf(1, umfc_pkg::MODE_UART9, 0, 0, 0, 9'h1A3, 9'h1A3, 9);
      xf(1, umfc_pkg::MODE_UART8, 0, 1, 0, 9'h01D, 9'h0E2, 8);
      xf(1, umfc_pkg::MODE_UART8, 0, 0, 0, 9'h01D, 9'h01D, 8);
      t_rate(8'h02, 1'b0, 48);
      t_rate(8'h00, 1'b1, 128);
      t_cts();
      t_rts();
      t_abort();
      close_out();
   end
   // all traffic needs about 8500 cycles; this leaves ample margin
   initial begin
      repeat (40000) @(posedge ref_clk);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
